// *** rtl/esli_pkg.sv ***
// Behaviour
// [RULE1] Events and alarms set latched status bits.
// [RULE2] Latched bit holds until read, then clears.
// [RULE3] Read cannot clear a still-present alarm bit.
// [RULE4] Written ones refresh readable bits; zeros hold.
// [RULE5] Host writes mask, reads, writes masked result.
// [RULE6] Synchronizer status is live and read-only.
// [RULE7] Masked status flags pull interrupt output low.
// [RULE8] Alarm change either way raises an interrupt.
// [RULE9] Reading alarm bit releases its interrupt.
// [RULE10] Event raises interrupt; reading bit releases it. Receive information events latch but raise none.
// [RULE11] Transmit store full/empty latch bits 7/6.
// [RULE12] Receive store full/empty latch bits 4/3.
// [RULE13] Jitter FIFO near limit latches bit 5.
// [RULE14] CRC resync criterion met latches bit 2.
// [RULE15] Frame alignment resync criterion latches bit 1.
// [RULE16] Signaling multiframe resync criterion latches bit 0.
// [RULE17] Sync counter bits 5,4,3,2,0 shown; bit 1 hidden.
// [RULE18] Bits 2..0 show three search-active flags.
// [RULE19] Counter counts timeouts, clears on lock/disable.
// [RULE20] Reset clears all flags; interrupt output high.
package esli_pkg;
    localparam logic [7:0] ESLI_OFF_SR_A = 8'h06;
    localparam logic [7:0] ESLI_OFF_SR_B = 8'h07;
    localparam logic [7:0] ESLI_OFF_RIR = 8'h08;
    localparam logic [7:0] ESLI_OFF_SSR = 8'h1E;
    localparam logic [7:0] ESLI_OFF_IMR_A = 8'h16;
    localparam logic [7:0] ESLI_OFF_IMR_B = 8'h17;
    localparam logic [7:0] ESLI_OFF_HDLC_IRQ_MASK = 8'h18;
    localparam logic [7:0] ESLI_RST_STATUS = 8'h00;
    localparam logic [7:0] ESLI_RST_MASK = 8'h00;
    localparam logic [7:0] ESLI_RST_RDATA = 8'h00;
    localparam int ESLI_CNT_W = 6;
    localparam logic [5:0] ESLI_RST_COUNT = 6'h00;
    // Status register a: bits 3..0 are alarms, bits 7..4 events.
    localparam logic [7:0] ESLI_SR_A_ALARMS = 8'h0F;
    localparam int ESLI_RIR_TX_FULL = 7;
    localparam int ESLI_RIR_TX_EMPTY = 6;
    localparam int ESLI_RIR_JIT_TRIP = 5;
    localparam int ESLI_RIR_RX_FULL = 4;
    localparam int ESLI_RIR_RX_EMPTY = 3;
    localparam int ESLI_RIR_CRC_RESYNC = 2;
    localparam int ESLI_RIR_FAS_RESYNC = 1;
    localparam int ESLI_RIR_CAS_RESYNC = 0;
    localparam int ESLI_SSR_CNT_LSB = 3;
    localparam int ESLI_SSR_FAS_SRCH = 2;
    localparam int ESLI_SSR_CAS_SRCH = 1;
    localparam int ESLI_SSR_CRC_SRCH = 0;
endpackage

// *** rtl/esli_cell.sv ***
`timescale 1ns/1ps
// One latched status bit with its read-back copy and interrupt source.
module esli_cell #(
    parameter bit IS_ALARM = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Condition: event pulse, or alarm level when IS_ALARM
    input wire logic cond,
    // Host side
    input wire logic refresh,
    input wire logic rd_clr,
    // State out
    output logic latch,
    output logic held,
    output logic irq
);
    typedef struct packed {
        logic latch;
        logic held;
        logic irq;
        logic prev;
    } esli_cell_t;

    esli_cell_t st_q;
    esli_cell_t st_d;
    logic chg;

    always_comb
    begin
        st_d = st_q;
        chg = IS_ALARM ? (cond ^ st_q.prev) : cond;
        // A set in the clearing cycle wins; a present alarm stays set.
        st_d.latch = cond | (st_q.latch & ~rd_clr); // [RULE1] [RULE2] [RULE3]
        if (refresh)
        begin
            st_d.held = st_q.latch; // [RULE4]
        end
        st_d.irq = chg | (st_q.irq & ~rd_clr); // [RULE8] [RULE9] [RULE10]
        st_d.prev = cond;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_q <= '0; // [RULE20]
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign latch = st_q.latch;
    assign held = st_q.held;
    assign irq = st_q.irq;
endmodule

// *** rtl/esli_status.sv ***
`timescale 1ns/1ps
// Status, information and synchronizer status registers of the framer.
// The host port is sampled on sys_clk; strobes last one cycle each.
module esli_status #(
    parameter int CNT_W = esli_pkg::ESLI_CNT_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Host parallel port
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic int_n,
    // Status register a: events 7..4, alarm levels 3..0
    input wire logic [7:0] sr_a_cond,
    // Status register b events
    input wire logic [7:0] sr_b_event,
    // Receive information events
    input wire logic tx_estore_full,
    input wire logic tx_estore_empty,
    input wire logic jitter_fifo_limit_trip,
    input wire logic rx_estore_full,
    input wire logic rx_estore_empty,
    input wire logic crc_resync_met,
    input wire logic frame_align_resync_met,
    input wire logic signaling_mf_resync_met,
    // HDLC status flags, latched inside the HDLC block
    input wire logic [7:0] hdlc_status_reg,
    // Synchronizer
    input wire logic frame_align_search_active,
    input wire logic signaling_mf_search_active,
    input wire logic crc_mf_search_active,
    input wire logic crc_mf_timeout,
    input wire logic crc_level_sync,
    input wire logic crc4_mode_en
);
    typedef struct packed {
        logic [7:0] irq_mask_a;
        logic [7:0] irq_mask_b;
        logic [7:0] hdlc_irq_mask;
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic [7:0] sel_r;
        logic [CNT_W-1:0] cnt;
        logic [7:0] rdata;
        logic int_n;
    } esli_state_t;

    esli_state_t st_q;
    esli_state_t st_d;

    logic wr_a;
    logic wr_b;
    logic wr_r;
    logic rd_a;
    logic rd_b;
    logic rd_r;
    logic [7:0] rir_event;
    logic [7:0] latch_a;
    logic [7:0] latch_b;
    logic [7:0] latch_r;
    logic [7:0] held_a;
    logic [7:0] held_b;
    logic [7:0] held_r;
    logic [7:0] irq_a;
    logic [7:0] irq_b;
    logic [7:0] irq_r;
    logic [7:0] ssr_val;
    logic pend;

    assign wr_a = host_wr && (host_addr == esli_pkg::ESLI_OFF_SR_A);
    assign wr_b = host_wr && (host_addr == esli_pkg::ESLI_OFF_SR_B);
    assign wr_r = host_wr && (host_addr == esli_pkg::ESLI_OFF_RIR);
    assign rd_a = host_rd && (host_addr == esli_pkg::ESLI_OFF_SR_A);
    assign rd_b = host_rd && (host_addr == esli_pkg::ESLI_OFF_SR_B);
    assign rd_r = host_rd && (host_addr == esli_pkg::ESLI_OFF_RIR);

    always_comb
    begin
        rir_event = '0;
        rir_event[esli_pkg::ESLI_RIR_TX_FULL] = tx_estore_full; // [RULE11]
        rir_event[esli_pkg::ESLI_RIR_TX_EMPTY] = tx_estore_empty; // [RULE11]
        rir_event[esli_pkg::ESLI_RIR_JIT_TRIP] = jitter_fifo_limit_trip; // [RULE13]
        rir_event[esli_pkg::ESLI_RIR_RX_FULL] = rx_estore_full; // [RULE12]
        rir_event[esli_pkg::ESLI_RIR_RX_EMPTY] = rx_estore_empty; // [RULE12]
        rir_event[esli_pkg::ESLI_RIR_CRC_RESYNC] = crc_resync_met; // [RULE14]
        rir_event[esli_pkg::ESLI_RIR_FAS_RESYNC] = frame_align_resync_met; // [RULE15]
        rir_event[esli_pkg::ESLI_RIR_CAS_RESYNC] = signaling_mf_resync_met; // [RULE16]
    end

    // A read clears only the bits that the preceding write selected.
    for (genvar i = 0; i < 8; i++)
    begin : g_bits
        esli_cell #(
            .IS_ALARM(esli_pkg::ESLI_SR_A_ALARMS[i])
        ) u_a (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .cond(sr_a_cond[i]),
            .refresh(wr_a && host_wdata[i]),
            .rd_clr(rd_a && st_q.sel_a[i]),
            .latch(latch_a[i]),
            .held(held_a[i]),
            .irq(irq_a[i])
        );
        esli_cell #(
            .IS_ALARM(1'b0)
        ) u_b (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .cond(sr_b_event[i]),
            .refresh(wr_b && host_wdata[i]),
            .rd_clr(rd_b && st_q.sel_b[i]),
            .latch(latch_b[i]),
            .held(held_b[i]),
            .irq(irq_b[i])
        );
        esli_cell #(
            .IS_ALARM(1'b0)
        ) u_r (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .cond(rir_event[i]),
            .refresh(wr_r && host_wdata[i]),
            .rd_clr(rd_r && st_q.sel_r[i]),
            .latch(latch_r[i]),
            .held(held_r[i]),
            .irq()
        );
    end

    // Counter bit 1 is kept but never shown.
    assign ssr_val = {st_q.cnt[5:2], st_q.cnt[0], // [RULE17]
        frame_align_search_active, signaling_mf_search_active, // [RULE18]
        crc_mf_search_active}; // [RULE6]

    assign irq_r = '0;
    assign pend = |(irq_a & st_q.irq_mask_a) | |(irq_b & st_q.irq_mask_b)
        | |(hdlc_status_reg & st_q.hdlc_irq_mask);

    always_comb
    begin
        st_d = st_q;
        st_d.int_n = ~pend; // [RULE7]
        if (wr_a)
        begin
            st_d.sel_a = host_wdata;
        end
        if (wr_b)
        begin
            st_d.sel_b = host_wdata;
        end
        if (wr_r)
        begin
            st_d.sel_r = host_wdata;
        end
        if (host_wr)
        begin
            unique case (host_addr)
                esli_pkg::ESLI_OFF_IMR_A: st_d.irq_mask_a = host_wdata;
                esli_pkg::ESLI_OFF_IMR_B: st_d.irq_mask_b = host_wdata;
                esli_pkg::ESLI_OFF_HDLC_IRQ_MASK: st_d.hdlc_irq_mask = host_wdata;
                default: st_d.sel_a = st_d.sel_a;
            endcase
        end
        if (host_rd)
        begin
            unique case (host_addr)
                esli_pkg::ESLI_OFF_SR_A: st_d.rdata = held_a;
                esli_pkg::ESLI_OFF_SR_B: st_d.rdata = held_b;
                esli_pkg::ESLI_OFF_RIR: st_d.rdata = held_r;
                esli_pkg::ESLI_OFF_SSR: st_d.rdata = ssr_val; // [RULE6]
                esli_pkg::ESLI_OFF_IMR_A: st_d.rdata = st_q.irq_mask_a;
                esli_pkg::ESLI_OFF_IMR_B: st_d.rdata = st_q.irq_mask_b;
                esli_pkg::ESLI_OFF_HDLC_IRQ_MASK: st_d.rdata = st_q.hdlc_irq_mask;
                default: st_d.rdata = esli_pkg::ESLI_RST_RDATA;
            endcase
        end
        if (!crc4_mode_en || crc_level_sync)
        begin
            st_d.cnt = esli_pkg::ESLI_RST_COUNT; // [RULE19]
        end
        else if (crc_mf_timeout)
        begin
            st_d.cnt = st_q.cnt + 1'b1; // [RULE19]
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_q.irq_mask_a <= esli_pkg::ESLI_RST_MASK;
            st_q.irq_mask_b <= esli_pkg::ESLI_RST_MASK;
            st_q.hdlc_irq_mask <= esli_pkg::ESLI_RST_MASK;
            st_q.sel_a <= esli_pkg::ESLI_RST_STATUS;
            st_q.sel_b <= esli_pkg::ESLI_RST_STATUS;
            st_q.sel_r <= esli_pkg::ESLI_RST_STATUS;
            st_q.cnt <= esli_pkg::ESLI_RST_COUNT;
            st_q.rdata <= esli_pkg::ESLI_RST_RDATA;
            st_q.int_n <= 1'b1; // [RULE20]
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign host_rdata = st_q.rdata;
    assign int_n = st_q.int_n;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    int_reset_a: assert property ( // [RULE20]
        $rose(rst_n) |-> int_n && held_a == 8'h00 && latch_r == 8'h00)
        else $error("interrupt or flags not idle after reset");

    ssr_live_a: assert property ( // [RULE6]
        host_rd && host_addr == esli_pkg::ESLI_OFF_SSR
        |=> host_rdata == $past(ssr_val))
        else $error("synchronizer status read not live");

    ssr_map_a: assert property ( // [RULE17]
        ssr_val[7:3] == {st_q.cnt[5:2], st_q.cnt[0]}
        && ssr_val[2:0] == {frame_align_search_active,
        signaling_mf_search_active, crc_mf_search_active})
        else $error("synchronizer status layout wrong");

    cnt_step_a: assert property ( // [RULE19]
        crc_mf_timeout && crc4_mode_en && !crc_level_sync
        |=> st_q.cnt == $past(st_q.cnt) + 6'h01)
        else $error("sync counter did not step");

    cnt_clear_a: assert property ( // [RULE19]
        !crc4_mode_en || crc_level_sync |=> st_q.cnt == 6'h00)
        else $error("sync counter not cleared");

    tx_store_a: assert property ( // [RULE11]
        tx_estore_full ##1 !(rd_r && st_q.sel_r[7])
        |=> latch_r[7])
        else $error("transmit store full not latched");

    rx_store_a: assert property ( // [RULE12]
        rx_estore_empty |=> latch_r[3])
        else $error("receive store empty not latched");

    resync_bits_a: assert property ( // [RULE14]
        crc_resync_met && frame_align_resync_met
        && signaling_mf_resync_met |=> latch_r[2:0] == 3'h7)
        else $error("resync criteria not latched");

    jitter_trip_a: assert property ( // [RULE13]
        jitter_fifo_limit_trip |=> latch_r[5])
        else $error("jitter trip not latched");

    hold_latch_a: assert property ( // [RULE2]
        latch_b[0] && !(rd_b && st_q.sel_b[0]) |=> latch_b[0])
        else $error("event bit lost before read");

    alarm_stays_a: assert property ( // [RULE3]
        rd_a && st_q.sel_a[0] && sr_a_cond[0] |=> latch_a[0])
        else $error("present alarm cleared by read");

    mask_hold_a: assert property ( // [RULE4]
        wr_r && !host_wdata[4] |=> held_r[4] == $past(held_r[4]))
        else $error("unselected readable bit changed");

    alarm_irq_a: assert property ( // [RULE8]
        $fell(sr_a_cond[1]) && st_q.irq_mask_a[1]
        ##1 st_q.irq_mask_a[1] |=> !int_n)
        else $error("alarm clearing raised no interrupt");

    alarm_rel_a: assert property ( // [RULE9]
        rd_a && st_q.sel_a[2] && $stable(sr_a_cond[2])
        |=> !irq_a[2])
        else $error("alarm interrupt not released by read");

    event_rel_a: assert property ( // [RULE10]
        rd_b && st_q.sel_b[5] && !sr_b_event[5] |=> !irq_b[5])
        else $error("event interrupt not released by read");

    int_pin_a: assert property ( // [RULE7]
        ##1 int_n == !$past(pend))
        else $error("interrupt pin does not follow masked flags");

    clear_cov_c: cover property (
        wr_b ##1 rd_b ##1 wr_b ##1 !int_n);
    alarm_cov_c: cover property (
        $rose(sr_a_cond[3]) ##[1:20] $fell(sr_a_cond[3]));
    wrap_cov_c: cover property (
        st_q.cnt == 6'h3F && crc_mf_timeout && crc4_mode_en);
endmodule

// *** verification/esli_host_model.sv ***
`timescale 1ns/1ps
// Host processor on the parallel port; idle lines carry inverted junk.
module esli_host_model (
    // Clock
    input wire logic sys_clk,
    // Parallel port
    output logic [7:0] host_addr,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata
);
    initial
    begin
        host_addr = 8'hFF;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'hA5;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge sys_clk);
        host_wr <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
    endtask

    // Data is taken two edges after it lands, while nothing can change it.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge sys_clk);
        host_rd <= 1'b0;
        host_addr <= ~a;
        repeat (2) @(posedge sys_clk);
        d = host_rdata;
    endtask

    // Mask, read, then write back the masked result so the bits clear.
    task automatic clr(input logic [7:0] a, input logic [7:0] m,
                       output logic [7:0] d);
        wr(a, m);
        rd(a, d);
        wr(a, d & m);
    endtask
endmodule

// *** verification/test_e1_status_latch_interrupt.sv ***
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        samples_checked++; \
        if ((a) !== (e)) \
        begin \
            miscompares++; \
            $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); \
        end \
    end

module test_e1_status_latch_interrupt;
    logic sys_clk, rst_n, host_wr, host_rd, int_n;
    logic [7:0] host_addr, host_wdata, host_rdata;
    logic [7:0] sr_a_cond, sr_b_event, rir_ev, hdlc;
    logic [2:0] srch;
    logic tmo_p, lvl_sync, mode_en;
    logic [7:0] d;
    int miscompares;
    int samples_checked;

    esli_host_model i_esli_host_model (
        .sys_clk(sys_clk), .host_addr(host_addr), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata)
    );

    esli_status #(.CNT_W(6)) i_esli_status (
        .sys_clk(sys_clk), .rst_n(rst_n), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .int_n(int_n), .sr_a_cond(sr_a_cond),
        .sr_b_event(sr_b_event), .tx_estore_full(rir_ev[7]),
        .tx_estore_empty(rir_ev[6]), .jitter_fifo_limit_trip(rir_ev[5]),
        .rx_estore_full(rir_ev[4]), .rx_estore_empty(rir_ev[3]),
        .crc_resync_met(rir_ev[2]), .frame_align_resync_met(rir_ev[1]),
        .signaling_mf_resync_met(rir_ev[0]), .hdlc_status_reg(hdlc),
        .frame_align_search_active(srch[2]),
        .signaling_mf_search_active(srch[1]),
        .crc_mf_search_active(srch[0]), .crc_mf_timeout(tmo_p),
        .crc_level_sync(lvl_sync), .crc4_mode_en(mode_en)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic pulse(input logic [7:0] b, input logic [7:0] r);
        @(posedge sys_clk);
        sr_b_event <= b;
        rir_ev <= r;
        @(posedge sys_clk);
        sr_b_event <= 8'h00;
        rir_ev <= 8'h00;
    endtask

    task automatic tmo(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            tmo_p <= 1'b1;
            @(posedge sys_clk);
            tmo_p <= 1'b0;
        end
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        i_esli_host_model.rd(a, v);
        `CHK(v, e)
    endtask

    task automatic close_out;
        $display("Counts: %0d checked, %0d mismatches", samples_checked,
                 miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        close_out;
    end

    initial
    begin
        rst_n = 1'b0;
        {sr_a_cond, sr_b_event, rir_ev, hdlc} = 32'h0000_0000;
        {srch, tmo_p, lvl_sync, mode_en} = 6'h01;
        miscompares = 0;
        samples_checked = 0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(1);
        `CHK(int_n, 1'b1)
        chk_rd(8'h08, 8'h00);
        chk_rd(8'h3F, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            pulse(8'h00, 8'h01 << i);
            i_esli_host_model.clr(8'h08, 8'h01 << i, d);
            `CHK(d, 8'h01 << i)
            i_esli_host_model.wr(8'h08, 8'h01 << i);
            chk_rd(8'h08, 8'h00);
        end
        pulse(8'h00, 8'h81);
        i_esli_host_model.wr(8'h08, 8'h01);
        chk_rd(8'h08, 8'h01);
        i_esli_host_model.wr(8'h08, 8'h80);
        chk_rd(8'h08, 8'h81);
        $display("test latch done");
        pulse(8'h02, 8'h00);
        settle(3);
        `CHK(int_n, 1'b1)
        i_esli_host_model.clr(8'h07, 8'h02, d);
        i_esli_host_model.wr(8'h17, 8'h01);
        pulse(8'h01, 8'h00);
        settle(3);
        `CHK(int_n, 1'b0)
        i_esli_host_model.clr(8'h07, 8'h01, d);
        `CHK(d, 8'h01)
        settle(2);
        `CHK(int_n, 1'b1)
        $display("test event done");
        i_esli_host_model.wr(8'h16, 8'h01);
        @(posedge sys_clk);
        sr_a_cond[0] <= 1'b1;
        settle(3);
        `CHK(int_n, 1'b0)
        i_esli_host_model.clr(8'h06, 8'h01, d);
        settle(2);
        `CHK(int_n, 1'b1)
        i_esli_host_model.clr(8'h06, 8'h01, d);
        `CHK(d, 8'h01)
        @(posedge sys_clk);
        sr_a_cond[0] <= 1'b0;
        settle(3);
        `CHK(int_n, 1'b0)
        i_esli_host_model.clr(8'h06, 8'h01, d);
        settle(2);
        `CHK(int_n, 1'b1)
        i_esli_host_model.wr(8'h06, 8'h01);
        chk_rd(8'h06, 8'h00);
        $display("test alarm done");
        i_esli_host_model.wr(8'h18, 8'h80);
        @(posedge sys_clk);
        hdlc <= 8'h80;
        settle(3);
        `CHK(int_n, 1'b0)
        @(posedge sys_clk);
        hdlc <= 8'h00;
        settle(3);
        `CHK(int_n, 1'b1)
        $display("test hdlc done");
        @(posedge sys_clk);
        srch <= 3'b101;
        tmo(2);
        chk_rd(8'h1E, 8'h05);
        tmo(4);
        chk_rd(8'h1E, 8'h15);
        tmo(59);
        chk_rd(8'h1E, 8'h0D);
        @(posedge sys_clk);
        lvl_sync <= 1'b1;
        @(posedge sys_clk);
        lvl_sync <= 1'b0;
        chk_rd(8'h1E, 8'h05);
        tmo(3);
        i_esli_host_model.wr(8'h1E, 8'hFF);
        chk_rd(8'h1E, 8'h0D);
        @(posedge sys_clk);
        mode_en <= 1'b0;
        srch <= 3'b010;
        chk_rd(8'h1E, 8'h02);
        $display("test sync done");
        close_out;
    end
endmodule
